// *** rtl/cag_defs.svh ***
// address generation constants: bases, windows, limits and reset values
`ifndef CAG_DEFS_SVH
`define CAG_DEFS_SVH
`define CAG_FIXED_CALL_BASE 16'h0800
`define CAG_TABLE_BASE      16'h0040
`define CAG_SADDR_HI_LOW    8'hfe
`define CAG_SADDR_HI_HIGH   8'hff
`define CAG_SADDR_WRAP      8'h20
`define CAG_SFR_HI          8'hff
`define CAG_SFR_GAP_LO      8'hd0
`define CAG_SFR_GAP_HI      8'hdf
`define CAG_GPR_BASE        16'hfee0
`define CAG_STACK_LO        16'hfb00
`define CAG_STACK_HI        16'hfeff
`define CAG_SP_RESET        16'hfee0
`define CAG_PC_RESET        16'h0000
`define CAG_BANK_RESET      2'h0
`endif

// *** rtl/cag_pkg.sv ***
// types shared by the address generation block
`default_nettype none
package cag_pkg;
  typedef enum logic [2:0] {
    CAG_PC_SEQ      = 3'b000,
    CAG_PC_REL      = 3'b001,
    CAG_PC_IMM16    = 3'b010,
    CAG_PC_FIXED    = 3'b011,
    CAG_PC_TABLE    = 3'b100,
    CAG_PC_REG      = 3'b101
  } cag_pc_mode_e;

  typedef enum logic [3:0] {
    CAG_OP_IMPLIED  = 4'b0000,
    CAG_OP_REG8     = 4'b0001,
    CAG_OP_REG16    = 4'b0010,
    CAG_OP_DIRECT   = 4'b0011,
    CAG_OP_SHORT    = 4'b0100,
    CAG_OP_SFR      = 4'b0101,
    CAG_OP_IND_DE   = 4'b0110,
    CAG_OP_IND_HL   = 4'b0111,
    CAG_OP_BASED    = 4'b1000,
    CAG_OP_IDX_B    = 4'b1001,
    CAG_OP_IDX_C    = 4'b1010,
    CAG_OP_PUSH     = 4'b1011,
    CAG_OP_POP      = 4'b1100
  } cag_op_mode_e;

  // one decoded instruction as seen by the address generator
  typedef struct packed {
    logic         valid;
    cag_pc_mode_e pc_mode;
    cag_op_mode_e op_mode;
    logic         word;      // 16-bit operand access
    logic [2:0]   length;    // instruction length in bytes
    logic [15:0]  imm16;     // immediate field, low byte also used as 8-bit immediate
    logic [4:0]   table_idx; // opcode immediate bits 1 to 5
    logic [2:0]   reg_code;  // register or pair code
  } cag_req_s;

  // general register values of the selected bank
  typedef struct packed {
    logic [15:0] ax;
    logic [15:0] pointer_pair;
    logic [15:0] base_pair;
    logic [7:0]  b;
    logic [7:0]  c;
  } cag_regs_s;
endpackage : cag_pkg
`default_nettype wire

// *** rtl/cag_addr_gen.sv ***
// branch target, program counter and operand address generation for the cpu core
`include "cag_defs.svh"
`default_nettype none
// Behaviour
// RQ1: relative branch adds sign-extended 8-bit displacement to next instruction address
// RQ2: short branch and all conditional branches use the relative target
// RQ3: long call and long branch load the 16-bit immediate into pc
// RQ4: fixed-area call target lies within 0800H to 0FFFH from 11-bit immediate
// RQ5: table call reads entry selected by opcode bits 1-5 in 40H-7FH
// RQ6: register branch copies the accumulator pair into pc
// RQ7: without a branch pc advances by the instruction length
// RQ8: implied operands address the accumulator or accumulator pair
// RQ9: register operand address combines bank select with the opcode register code
// RQ10: direct addressing uses the 16-bit immediate as operand address
// RQ11: short direct maps 8-bit immediate into FE20H-FF1FH, bit 8 set below 20H
// RQ12: 16-bit short direct accesses are allowed at even addresses only
// RQ13: special-register addressing covers FF00H-FFCFH and FFE0H-FFFFH
// RQ14: 16-bit special-register accesses are allowed at even addresses only
// RQ15: register indirect uses pointer or base pair of the current bank
// RQ16: based adds zero-extended offset to base pair, carry dropped
// RQ17: based indexed adds zero-extended B or C to base pair, carry dropped
// RQ18: stack accesses go through the stack pointer within high-speed ram
// RQ19: stack pointer decrements before a write and increments after a read
// RQ20: two-bit bank select field picks one of four banks
// RQ21: the four banks of eight registers sit at FEE0H to FEFFH
// RQ22: special-register address is a fixed FF high byte joined to the immediate
// RQ23: all 16-bit address sums wrap modulo 65536 without any exception
module cag_addr_gen
  import cag_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire cag_req_s    i_req,
  input  wire cag_regs_s   i_regs,
  input  wire logic        i_taken,
  input  wire logic [15:0] i_table_entry,
  input  wire logic        i_bank_we,
  input  wire logic [1:0]  i_bank_sel,
  input  wire logic        i_sp_we,
  input  wire logic [15:0] i_sp_wdata,
  output logic [15:0]      o_pc,
  output logic [15:0]      o_table_addr,
  output logic [15:0]      o_op_addr,
  output logic             o_op_valid,
  output logic             o_op_fault,
  output logic [15:0]      o_sp,
  output logic             o_bank_select_low,
  output logic             o_bank_select_high
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  logic [15:0] pc;
  logic [15:0] sp;
  logic [1:0]  bank;
  logic [15:0] op_addr;
  logic        op_valid;
  logic        op_fault;
  logic [15:0] next_pc;
  logic [15:0] next_sp;
  logic [1:0]  next_bank;
  logic [15:0] next_op_addr;
  logic        next_op_valid;
  logic        next_op_fault;

  // ------------------------------------------------------------
  // combinational helpers
  // ------------------------------------------------------------
  logic [15:0] seq_pc;
  logic [15:0] rel_pc;
  logic [15:0] gpr_bank_base;
  logic [7:0]  imm8;
  logic [15:0] short_addr;
  logic [15:0] sfr_addr;
  logic        sfr_in_gap;

  assign imm8          = i_req.imm16[7:0];
  // address of the following instruction, wraps at 64k
  assign seq_pc        = pc + {13'h0000, i_req.length}; // RQ7 RQ23
  // sign extension makes the reach -128 .. +127 around the next instruction
  assign rel_pc        = seq_pc + {{8{imm8[7]}}, imm8}; // RQ1 RQ23
  // bank 0 occupies the top eight bytes, bank 3 the bottom eight
  assign gpr_bank_base = `CAG_GPR_BASE + {11'h000, ~bank, 3'h0}; // RQ20 RQ21
  // high byte fe from 20H upward, ff below it: only bit 8 differs
  assign short_addr    = {(imm8 < `CAG_SADDR_WRAP) ? `CAG_SADDR_HI_HIGH : `CAG_SADDR_HI_LOW, imm8}; // RQ11
  // no adder in this path, the high byte is a constant
  assign sfr_addr      = {`CAG_SFR_HI, imm8}; // RQ22
  assign sfr_in_gap    = (imm8 >= `CAG_SFR_GAP_LO) && (imm8 <= `CAG_SFR_GAP_HI); // RQ13

  // table entry location: two bytes per entry from 40H
  assign o_table_addr  = `CAG_TABLE_BASE + {10'h000, i_req.table_idx, 1'b0}; // RQ5

  // ------------------------------------------------------------
  // program counter next value
  // ------------------------------------------------------------
  always_comb begin
    next_pc = pc;
    if (i_req.valid) begin
      case (i_req.pc_mode)
        CAG_PC_SEQ:   next_pc = seq_pc; // RQ7
        CAG_PC_REL:   next_pc = i_taken ? rel_pc : seq_pc; // RQ2
        CAG_PC_IMM16: next_pc = i_req.imm16; // RQ3
        CAG_PC_FIXED: next_pc = `CAG_FIXED_CALL_BASE | {5'h00, i_req.imm16[10:0]}; // RQ4
        CAG_PC_TABLE: next_pc = i_table_entry; // RQ5
        CAG_PC_REG:   next_pc = i_regs.ax; // RQ6
        default:      next_pc = seq_pc;
      endcase
    end
  end

  // ------------------------------------------------------------
  // operand address, fault flag and stack pointer next values
  // ------------------------------------------------------------
  always_comb begin
    next_op_addr  = op_addr;
    next_op_valid = 1'b0;
    next_op_fault = 1'b0;
    next_sp       = sp;
    if (i_req.valid) begin
      next_op_valid = 1'b1;
      case (i_req.op_mode)
        // accumulator a is register code 1, pair ax is code 0
        CAG_OP_IMPLIED: next_op_addr = gpr_bank_base + (i_req.word ? 16'h0000 : 16'h0001); // RQ8
        CAG_OP_REG8:    next_op_addr = gpr_bank_base + {13'h0000, i_req.reg_code}; // RQ9
        CAG_OP_REG16:   next_op_addr = gpr_bank_base + {13'h0000, i_req.reg_code[1:0], 1'b0}; // RQ9
        CAG_OP_DIRECT:  next_op_addr = i_req.imm16; // RQ10
        CAG_OP_SHORT: begin
          next_op_addr  = short_addr; // RQ11
          next_op_fault = i_req.word & imm8[0]; // RQ12
        end
        CAG_OP_SFR: begin
          next_op_addr  = sfr_addr; // RQ22
          next_op_fault = sfr_in_gap | (i_req.word & imm8[0]); // RQ13 RQ14
        end
        CAG_OP_IND_DE:  next_op_addr = i_regs.pointer_pair; // RQ15
        CAG_OP_IND_HL:  next_op_addr = i_regs.base_pair; // RQ15
        CAG_OP_BASED:   next_op_addr = i_regs.base_pair + {8'h00, imm8}; // RQ16 RQ23
        CAG_OP_IDX_B:   next_op_addr = i_regs.base_pair + {8'h00, i_regs.b}; // RQ17 RQ23
        CAG_OP_IDX_C:   next_op_addr = i_regs.base_pair + {8'h00, i_regs.c}; // RQ17 RQ23
        CAG_OP_PUSH: begin
          // pre-decrement: the write lands at the lowered pointer
          next_sp       = sp - (i_req.word ? 16'h0002 : 16'h0001); // RQ19
          next_op_addr  = next_sp; // RQ18
          next_op_fault = (next_sp < `CAG_STACK_LO) || (next_sp > `CAG_STACK_HI); // RQ18
        end
        CAG_OP_POP: begin
          // read at the current pointer, increment afterwards
          next_op_addr  = sp; // RQ18
          next_sp       = sp + (i_req.word ? 16'h0002 : 16'h0001); // RQ19
          next_op_fault = (sp < `CAG_STACK_LO) || (sp > `CAG_STACK_HI); // RQ18
        end
        default: begin
          next_op_valid = 1'b0;
        end
      endcase
    end
    // an explicit load of the pointer overrides any stack step
    if (i_sp_we) begin
      next_sp = i_sp_wdata;
    end
  end

  // ------------------------------------------------------------
  // bank select next value
  // ------------------------------------------------------------
  always_comb begin
    next_bank = bank;
    if (i_bank_we) begin
      next_bank = i_bank_sel; // RQ20
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // the stack pointer resets to a defined value for determinism, software must still set it
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pc       <= `CAG_PC_RESET;
      sp       <= `CAG_SP_RESET;
      bank     <= `CAG_BANK_RESET;
      op_addr  <= 16'h0000;
      op_valid <= 1'b0;
      op_fault <= 1'b0;
    end else begin
      pc       <= next_pc;
      sp       <= next_sp;
      bank     <= next_bank;
      op_addr  <= next_op_addr;
      op_valid <= next_op_valid;
      op_fault <= next_op_fault;
    end
  end

  assign o_pc               = pc;
  assign o_sp               = sp;
  assign o_op_addr          = op_addr;
  assign o_op_valid         = op_valid;
  assign o_op_fault         = op_fault;
  assign o_bank_select_low  = bank[0];
  assign o_bank_select_high = bank[1];

endmodule : cag_addr_gen
`default_nettype wire

// *** test/cag_addr_gen_assertions.sv ***
// assertion checker for the address generation block
`default_nettype none
module cag_addr_gen_assertions
  import cag_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_rst,
  input wire cag_req_s    i_req,
  input wire cag_regs_s   i_regs,
  input wire logic        i_taken,
  input wire logic        i_sp_we,
  input wire logic [15:0] o_pc,
  input wire logic [15:0] o_table_addr,
  input wire logic [15:0] o_op_addr,
  input wire logic        o_op_fault,
  input wire logic [15:0] o_sp
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------
  // properties on the cpu clock
  // ---------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // shorthands keep each property but chk_push_pre to two lines
  wire logic        go = i_req.valid;
  wire logic [7:0]  im = i_req.imm16[7:0];
  wire logic [15:0] sx = {{8{i_req.imm16[7]}}, i_req.imm16[7:0]};
  chk_seq_step: assert property (go && i_req.pc_mode == CAG_PC_SEQ |=>
    o_pc == 16'($past(o_pc) + $past(i_req.length))) else $error("pc step wrong");
  chk_rel_taken: assert property (go && i_req.pc_mode == CAG_PC_REL && i_taken |=>
    o_pc == 16'($past(o_pc) + $past(i_req.length) + $past(sx))) else $error("relative target wrong");
  chk_long_target: assert property (go && i_req.pc_mode == CAG_PC_IMM16 |=>
    o_pc == $past(i_req.imm16)) else $error("long target wrong");
  chk_fixed_area: assert property (go && i_req.pc_mode == CAG_PC_FIXED |=>
    o_pc == {5'h01, $past(i_req.imm16[10:0])}) else $error("fixed call target wrong");
  chk_table_slot: assert property (go |-> o_table_addr == {10'h001, i_req.table_idx, 1'b0})
    else $error("table address wrong");
  chk_reg_branch: assert property (go && i_req.pc_mode == CAG_PC_REG |=>
    o_pc == $past(i_regs.ax)) else $error("register branch wrong");
  chk_short_map: assert property (go && i_req.op_mode == CAG_OP_SHORT |=>
    o_op_addr == {($past(im) < 8'h20) ? 8'hff : 8'hfe, $past(im)}) else $error("short address wrong");
  chk_sfr_join: assert property (go && i_req.op_mode == CAG_OP_SFR |=>
    o_op_addr == {8'hff, $past(im)}) else $error("sfr address wrong");
  chk_based_wrap: assert property (go && i_req.op_mode == CAG_OP_BASED |=>
    o_op_addr == 16'($past(i_regs.base_pair) + $past(im))) else $error("based address wrong");
  chk_push_pre: assert property (go && i_req.op_mode == CAG_OP_PUSH && !i_sp_we |=>
    o_op_addr == o_sp && o_sp == 16'($past(o_sp) - ($past(i_req.word) ? 16'h2 : 16'h1)))
    else $error("push pointer wrong");
  chk_odd_word: assert property (go && i_req.op_mode == CAG_OP_SHORT && i_req.word && im[0] |=>
    o_op_fault) else $error("odd word access not flagged");
  cov_rel_taken: cover property (go && i_req.pc_mode == CAG_PC_REL && i_taken);
  cov_table: cover property (go && i_req.pc_mode == CAG_PC_TABLE);
  cov_push: cover property (go && i_req.op_mode == CAG_OP_PUSH);
endmodule : cag_addr_gen_assertions
bind cag_addr_gen cag_addr_gen_assertions u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req),
  .i_regs(i_regs), .i_taken(i_taken), .i_sp_we(i_sp_we), .o_pc(o_pc), .o_table_addr(o_table_addr),
  .o_op_addr(o_op_addr), .o_op_fault(o_op_fault), .o_sp(o_sp));
`default_nettype wire

// *** test/cag_addr_gen_test.sv ***
// self-checking testbench for the address generation block
`default_nettype none
module cag_addr_gen_test
  import cag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    cag_pc_mode_e pm;
    cag_op_mode_e om;
    logic         w;
    logic [2:0]   len;
    logic [15:0]  imm;
    logic [4:0]   ti;
    logic [2:0]   rc;
    logic         tk;
    logic [15:0]  ea;
    logic         f;
  } cag_row_s;
  logic        i_clk = 1'b0;
  logic        i_rst = 1'b1;
  cag_req_s    i_req = '0;
  cag_regs_s   i_regs = '{16'h2468, 16'hfc10, 16'hfff0, 8'h30, 8'h05};
  logic        i_taken = 1'b0;
  logic        i_bank_we = 1'b0;
  logic [1:0]  i_bank_sel = 2'h0;
  logic        i_sp_we = 1'b0;
  logic [15:0] i_sp_wdata = 16'h0000;
  logic [15:0] i_table_entry, o_pc, o_table_addr, o_op_addr, o_sp;
  logic        o_op_valid, o_op_fault, o_bank_select_low, o_bank_select_high;
  logic [15:0] exp_pc = 16'h0000;
  int          failures = 0;
  int          n_compared = 0;
  // bank 0 registers sit at fef8, so register rows expect addresses there
  cag_row_s rows [16] = '{
    '{CAG_PC_SEQ, CAG_OP_DIRECT, 0, 2, 16'h1234, 0, 0, 0, 16'h1234, 0},
    '{CAG_PC_REL, CAG_OP_IMPLIED, 0, 2, 16'h0080, 0, 0, 1, 16'hfef9, 0},
    '{CAG_PC_REL, CAG_OP_REG8, 0, 2, 16'h007f, 0, 7, 1, 16'hfeff, 0},
    '{CAG_PC_REL, CAG_OP_REG16, 0, 2, 16'h0010, 0, 3, 0, 16'hfefe, 0},
    '{CAG_PC_IMM16, CAG_OP_SHORT, 0, 3, 16'hffff, 0, 0, 0, 16'hfeff, 0},
    '{CAG_PC_SEQ, CAG_OP_SHORT, 0, 1, 16'h001f, 0, 0, 0, 16'hff1f, 0},
    '{CAG_PC_SEQ, CAG_OP_SHORT, 1, 3, 16'h0020, 0, 0, 0, 16'hfe20, 0},
    '{CAG_PC_FIXED, CAG_OP_SHORT, 1, 3, 16'hf721, 0, 0, 0, 16'hfe21, 1},
    '{CAG_PC_TABLE, CAG_OP_SFR, 0, 1, 16'h00cf, 31, 0, 0, 16'hffcf, 0},
    '{CAG_PC_REG, CAG_OP_SFR, 0, 2, 16'h00d0, 0, 0, 0, 16'hffd0, 1},
    '{CAG_PC_SEQ, CAG_OP_SFR, 1, 4, 16'h00e1, 0, 0, 0, 16'hffe1, 1},
    '{CAG_PC_SEQ, CAG_OP_IND_DE, 0, 1, 16'h0000, 0, 0, 0, 16'hfc10, 0},
    '{CAG_PC_SEQ, CAG_OP_BASED, 0, 1, 16'h0020, 0, 0, 0, 16'h0010, 0},
    '{CAG_PC_SEQ, CAG_OP_IDX_B, 0, 1, 16'h0000, 0, 0, 0, 16'h0020, 0},
    '{CAG_PC_SEQ, CAG_OP_IDX_C, 0, 1, 16'h0000, 0, 0, 0, 16'hfff5, 0},
    '{CAG_PC_SEQ, CAG_OP_IMPLIED, 1, 1, 16'h0000, 0, 0, 0, 16'hfef8, 0}};
  // table memory stand-in: the entry's high byte echoes the low byte of its address, so a wrong slot shows in pc
  assign i_table_entry = {o_table_addr[7:0], 8'ha5};
  initial begin
    forever #2.5 i_clk = ~i_clk;
  end
  cag_addr_gen u_cag_addr_gen (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_regs(i_regs),
    .i_taken(i_taken), .i_table_entry(i_table_entry), .i_bank_we(i_bank_we), .i_bank_sel(i_bank_sel),
    .i_sp_we(i_sp_we), .i_sp_wdata(i_sp_wdata), .o_pc(o_pc), .o_table_addr(o_table_addr),
    .o_op_addr(o_op_addr), .o_op_valid(o_op_valid), .o_op_fault(o_op_fault), .o_sp(o_sp),
    .o_bank_select_low(o_bank_select_low), .o_bank_select_high(o_bank_select_high));
  // ---------------------------------
  // reference and helpers
  // ---------------------------------
  function automatic logic [15:0] next_pc(input logic [15:0] pc, input cag_row_s r);
    case (r.pm)
      CAG_PC_REL:   next_pc = 16'(pc + r.len + (r.tk ? {{8{r.imm[7]}}, r.imm[7:0]} : 16'h0000));
      CAG_PC_IMM16: next_pc = r.imm;
      CAG_PC_FIXED: next_pc = {5'h01, r.imm[10:0]};
      CAG_PC_TABLE: next_pc = {8'h40 + {2'h0, r.ti, 1'b0}, 8'ha5};
      CAG_PC_REG:   next_pc = 16'h2468;
      default:      next_pc = 16'(pc + r.len);
    endcase
  endfunction : next_pc
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      failures++;
      $display("MISMATCH at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check
  // one request, then valid is lowered; outputs are checked one cycle later with op valid expected high
  task automatic run_row(input cag_row_s r);
    @(posedge i_clk);
    i_req <= '{1'b1, r.pm, r.om, r.w, r.len, r.imm, r.ti, r.rc};
    i_taken <= r.tk;
    exp_pc = next_pc(exp_pc, r);
    @(posedge i_clk);
    i_req.valid <= 1'b0;
    #1;
    check(o_pc, exp_pc);
    check(o_op_addr, r.ea);
    check({o_op_valid, o_op_fault}, {1'b1, r.f});
  endtask : run_row
  task automatic set_bank(input logic [1:0] b);
    @(posedge i_clk);
    i_bank_we <= 1'b1;
    i_bank_sel <= b;
    @(posedge i_clk);
    i_bank_we <= 1'b0;
    #1;
    check({o_bank_select_high, o_bank_select_low}, b);
  endtask : set_bank
  task automatic stop_test;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  // main sequence: reset, table rows, then banks and stack by hand
  initial begin
    repeat (6) @(posedge i_clk);
    i_rst <= 1'b0;
    #1;
    check(o_pc, 16'h0000);
    check({o_bank_select_high, o_bank_select_low, o_op_valid}, 3'h0);
    check({o_sp, o_op_fault}, {16'hfee0, 1'b0});
    check(o_op_addr, 16'h0000);
    foreach (rows[k]) begin
      run_row(rows[k]);
    end
    set_bank(2'h3);
    run_row('{CAG_PC_SEQ, CAG_OP_REG8, 0, 1, 16'h0000, 0, 0, 0, 16'hfee0, 0});
    set_bank(2'h2);
    run_row('{CAG_PC_SEQ, CAG_OP_REG16, 0, 1, 16'h0000, 0, 1, 0, 16'hfeea, 0});
    run_row('{CAG_PC_SEQ, CAG_OP_PUSH, 1, 1, 16'h0000, 0, 0, 0, 16'hfede, 0});
    check(o_sp, 16'hfede);
    run_row('{CAG_PC_SEQ, CAG_OP_POP, 0, 1, 16'h0000, 0, 0, 0, 16'hfede, 0});
    check(o_sp, 16'hfedf);
    @(posedge i_clk);
    i_sp_we <= 1'b1;
    i_sp_wdata <= 16'hfb00;
    @(posedge i_clk);
    i_sp_we <= 1'b0;
    #1;
    check(o_sp, 16'hfb00);
    run_row('{CAG_PC_SEQ, CAG_OP_PUSH, 0, 1, 16'h0000, 0, 0, 0, 16'hfaff, 1});
    // mid-run reset: pc, pointer and bank must all return to their reset values at once
    @(posedge i_clk);
    i_rst <= 1'b1;
    #1;
    check(o_pc, 16'h0000);
    check(o_sp, 16'hfee0);
    check({o_bank_select_high, o_bank_select_low, o_op_valid, o_op_fault}, 4'h0);
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    exp_pc = 16'h0000;
    // base pair indirect is only reached here, after the second release
    run_row('{CAG_PC_SEQ, CAG_OP_IND_HL, 0, 2, 16'h0000, 0, 0, 0, 16'hfff0, 0});
    run_row('{CAG_PC_SEQ, CAG_OP_REG8, 0, 1, 16'h0000, 0, 2, 0, 16'hfefa, 0});
    stop_test();
  end
endmodule : cag_addr_gen_test
`default_nettype wire
